// file: rcpt_pkg.sv
/*
 Constants for the real-time counter and periodic timer: register
 indices, field positions, reset values and synchroniser settings.
 Assumes an APB slave whose byte address is four times the index.
*/
package rcpt_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CTRLA    = 6'h00;
    localparam logic [5:0] IDX_STATUS   = 6'h01;
    localparam logic [5:0] IDX_INTCTRL  = 6'h02;
    localparam logic [5:0] IDX_INTFLAGS = 6'h03;
    localparam logic [5:0] IDX_TEMP     = 6'h04;
    localparam logic [5:0] IDX_HALT     = 6'h05;
    localparam logic [5:0] IDX_SRCSEL   = 6'h07;
    localparam logic [5:0] IDX_CNT_L    = 6'h08;
    localparam logic [5:0] IDX_CNT_H    = 6'h09;
    localparam logic [5:0] IDX_TOP_L    = 6'h0A;
    localparam logic [5:0] IDX_TOP_H    = 6'h0B;
    localparam logic [5:0] IDX_MATCH_L  = 6'h0C;
    localparam logic [5:0] IDX_MATCH_H  = 6'h0D;
    localparam logic [5:0] IDX_PCTRL    = 6'h10;
    localparam logic [5:0] IDX_PSTAT    = 6'h11;
    localparam logic [5:0] IDX_PIRQEN   = 6'h12;
    localparam logic [5:0] IDX_PFLAGS   = 6'h13;
    localparam logic [5:0] IDX_PDBG     = 6'h15;

    // ------------------------------------------------------------
    // Fields, codes and reset values
    // ------------------------------------------------------------
    localparam int         ON_BIT       = 0;
    localparam int         DIV_LSB      = 3;
    localparam int         PERIOD_LSB   = 3;
    localparam logic [7:0] CTRLA_MASK   = 8'hF9;
    localparam logic [7:0] PCTRL_MASK   = 8'h79;
    localparam logic [1:0] SRC_FAST     = 2'h0;
    localparam logic [1:0] SRC_SLOW     = 2'h1;
    localparam logic [1:0] SRC_RSVD     = 2'h2;
    localparam logic [1:0] SRC_EXT      = 2'h3;
    localparam logic [3:0] PIT_OFF      = 4'h0;
    localparam logic [3:0] PIT_RSVD     = 4'hF;
    localparam logic [15:0] TOP_RST     = 16'hFFFF;
    localparam logic [15:0] ZERO16      = 16'h0000;

    // ------------------------------------------------------------
    // Write synchronisation slots and latency in timebase ticks
    // ------------------------------------------------------------
    localparam int         SY_CTRLA     = 0;
    localparam int         SY_CNT       = 1;
    localparam int         SY_TOP       = 2;
    localparam int         SY_MATCH     = 3;
    localparam int         SY_PIT       = 4;
    localparam int         NSYNC        = 5;
    localparam logic [1:0] SYNC_TICKS   = 2'h2;

endpackage : rcpt_pkg

// file: rcpt_tick_if.sv
/*
 Carrier between the core and the timebase source selector.
 Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface rcpt_tick_if;
    logic [1:0] source_select;
    logic       tick;
    modport src  (input source_select, output tick);
    modport core (output source_select, input tick);
endinterface : rcpt_tick_if

// file: rcpt_tick_src.sv
/*
 Timebase source selector: synchronises the three timebase clock pins
 into pclk and emits a one-cycle tick on each rising edge of the chosen one.
 Assumes every timebase clock is far slower than pclk.
*/
`timescale 1ns/1ps
module rcpt_tick_src
    import rcpt_pkg::*;
#(
    parameter int N = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] src_pins,
    rcpt_tick_if.src          tb
);

    typedef struct packed {
        logic [N-1:0] m1;
        logic [N-1:0] m2;
        logic [N-1:0] d;
        logic         tick;
    } rcpt_sync_s;

    rcpt_sync_s s_r;
    rcpt_sync_s s_nxt;
    logic [N-1:0] edges;

    // Two-flop synchroniser, delay stage and edge select
    always_comb begin
        s_nxt    = s_r;
        s_nxt.m1 = src_pins;
        s_nxt.m2 = s_r.m1;
        s_nxt.d  = s_r.m2;
        edges    = s_r.m2 & ~s_r.d;
        case (tb.source_select)
            SRC_FAST: s_nxt.tick = edges[0];
            SRC_SLOW: s_nxt.tick = edges[1];
            SRC_EXT:  s_nxt.tick = edges[2];
            default:  s_nxt.tick = 1'b0;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tb.tick = s_r.tick;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    reserved_src_a: assert property (s_r.tick |-> $past(tb.source_select) != SRC_RSVD)
        else $error("tick produced from reserved source");

endmodule : rcpt_tick_src

// file: rcpt_core.sv
/*
 Real-time counter with wrap-top and match values, prescaler, periodic
 interval timer and debug-halt control, reached over APB.
 Assumes timebase clocks arrive on pins and dbg_halt comes from pclk logic.
*/
`timescale 1ns/1ps
module rcpt_core
    import rcpt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fast_internal_source_clk,
    input  wire logic        slow_internal_source_clk,
    input  wire logic        external_pin_source_clk,
    input  wire logic        dbg_halt,
    output logic             rtc_irq_req,
    output logic             periodic_irq_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                        pready;
        logic                        pslverr;
        logic [31:0]                 prdata;
        logic [7:0]                  temp;
        logic [7:0]                  ctrla;
        logic [7:0]                  ctrla_act;
        logic [1:0]                  int_en;
        logic [1:0]                  int_flag;
        logic                        halt_bypass;
        logic [1:0]                  source_select;
        logic [15:0]                 tick_count;
        logic [15:0]                 cnt_wr;
        logic [15:0]                 wrap_top;
        logic [15:0]                 top_act;
        logic [15:0]                 match_value;
        logic [15:0]                 match_act;
        logic [7:0]                  pctrl;
        logic [7:0]                  pctrl_act;
        logic                        pit_ie;
        logic                        periodic_irq;
        logic                        pit_bypass;
        logic [NSYNC-1:0]            pend;
        logic [NSYNC-1:0][1:0]       sync_cnt;
        logic [14:0]                 pre_cnt;
        logic [15:0]                 pit_cnt;
        logic                        rtc_irq;
        logic                        pit_irq;
    } rcpt_state_s;

    rcpt_state_s s_r;
    rcpt_state_s s_nxt;

    rcpt_tick_if tb_if ();

    logic             tick;
    logic             acc;
    logic             done;
    logic             wr;
    logic             rd;
    logic [5:0]       idx;
    logic [7:0]       wd;
    logic [8:0]       rsel;
    logic [NSYNC-1:0] apply;
    logic             run_cnt;
    logic [14:0]      div_mask;
    logic             div_tick;
    logic             wrap_evt;
    logic             match_evt;
    logic [1:0]       flag_clr;
    logic [3:0]       period;
    logic             pit_on;
    logic             pit_run;
    logic [15:0]      pit_last;
    logic             pit_evt;

    // ------------------------------------------------------------
    // Timebase source
    // ------------------------------------------------------------
    rcpt_tick_src #(
        .N (3)
    ) u_tick (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_pins ({external_pin_source_clk, slow_internal_source_clk,
                    fast_internal_source_clk}),
        .tb       (tb_if.src)
    );

    assign tb_if.source_select = s_r.source_select;
    assign tick                = tb_if.tick;

    // APB phase decode; one wait state before every answer
    assign acc  = psel & penable;
    assign done = acc & s_r.pready;
    assign wr   = done & pwrite & pstrb[0];
    assign rd   = done & ~pwrite;
    assign idx  = paddr[7:2];
    assign wd   = pwdata[7:0];

    // ------------------------------------------------------------
    // Read mux: {error, byte}
    // ------------------------------------------------------------
    function automatic logic [8:0] read_mux(input logic [5:0] a);
        logic [8:0] r;
        r = 9'h000;
        if (a == IDX_CTRLA) begin
            r = {1'b0, s_r.ctrla};
        end else if (a == IDX_STATUS) begin
            r = {5'h00, s_r.pend[SY_MATCH], s_r.pend[SY_TOP],
                 s_r.pend[SY_CNT], s_r.pend[SY_CTRLA]};
        end else if (a == IDX_INTCTRL) begin
            r = {7'h00, s_r.int_en};
        end else if (a == IDX_INTFLAGS) begin
            r = {7'h00, s_r.int_flag};
        end else if (a == IDX_TEMP) begin
            r = {1'b0, s_r.temp};
        end else if (a == IDX_HALT) begin
            r = {8'h00, s_r.halt_bypass};
        end else if (a == IDX_SRCSEL) begin
            r = {7'h00, s_r.source_select};
        end else if (a == IDX_CNT_L) begin
            r = {1'b0, s_r.tick_count[7:0]};
        end else if (a == IDX_TOP_L) begin
            r = {1'b0, s_r.wrap_top[7:0]};
        end else if (a == IDX_MATCH_L) begin
            r = {1'b0, s_r.match_value[7:0]};
        end else if (a == IDX_CNT_H || a == IDX_TOP_H || a == IDX_MATCH_H) begin
            r = {1'b0, s_r.temp};
        end else if (a == IDX_PCTRL) begin
            r = {1'b0, s_r.pctrl};
        end else if (a == IDX_PSTAT) begin
            r = {8'h00, s_r.pend[SY_PIT]};
        end else if (a == IDX_PIRQEN) begin
            r = {8'h00, s_r.pit_ie};
        end else if (a == IDX_PFLAGS) begin
            r = {8'h00, s_r.periodic_irq};
        end else if (a == IDX_PDBG) begin
            r = {8'h00, s_r.pit_bypass};
        end else begin
            r = 9'h100;
        end
        return r;
    endfunction : read_mux

    // Read mux; re-evaluated on state changes too, so polling one index sees updates
    always_comb begin
        rsel = read_mux(idx);
    end

    // Divided tick and periodic limits
    assign run_cnt  = s_r.ctrla_act[ON_BIT] & (~dbg_halt | s_r.halt_bypass);
    assign div_mask = 15'((32'h1 << s_r.ctrla_act[DIV_LSB +: 4]) - 32'h1);
    assign div_tick = tick & run_cnt & ((s_r.pre_cnt & div_mask) == div_mask);
    assign period   = s_r.pctrl_act[PERIOD_LSB +: 4];
    assign pit_on   = s_r.pctrl_act[ON_BIT] & (period != PIT_OFF)
                      & (period != PIT_RSVD);
    assign pit_run  = pit_on & (~dbg_halt | s_r.pit_bypass);
    assign pit_last = 16'((32'h1 << (32'(period) + 32'h1)) - 32'h1);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        apply     = '0;
        wrap_evt  = 1'b0;
        match_evt = 1'b0;
        pit_evt   = 1'b0;
        flag_clr  = 2'h0;

        // Bus answer
        s_nxt.pready = acc & ~s_r.pready;
        if (s_nxt.pready) begin
            s_nxt.prdata  = {24'h000000, (pwrite ? 8'h00 : rsel[7:0])};
            s_nxt.pslverr = rsel[8];
        end else begin
            s_nxt.prdata  = 32'h00000000;
            s_nxt.pslverr = 1'b0;
        end

        // Low-byte read latches the high byte
        if (rd) begin
            if (idx == IDX_CNT_L) begin
                s_nxt.temp = s_r.tick_count[15:8];
            end else if (idx == IDX_TOP_L) begin
                s_nxt.temp = s_r.wrap_top[15:8];
            end else if (idx == IDX_MATCH_L) begin
                s_nxt.temp = s_r.match_value[15:8];
            end
        end

        // Crossing into timebase: count two ticks then apply
        for (int i = 0; i < NSYNC; i++) begin
            if (tick && s_r.pend[i]) begin
                if (s_r.sync_cnt[i] == SYNC_TICKS - 2'h1) begin
                    apply[i]          = 1'b1;
                    s_nxt.pend[i]     = 1'b0;
                    s_nxt.sync_cnt[i] = 2'h0;
                end else begin
                    s_nxt.sync_cnt[i] = s_r.sync_cnt[i] + 2'h1;
                end
            end
        end
        if (apply[SY_CTRLA]) begin
            s_nxt.ctrla_act = s_r.ctrla;
        end
        if (apply[SY_TOP]) begin
            s_nxt.top_act = s_r.wrap_top;
        end
        if (apply[SY_MATCH]) begin
            s_nxt.match_act = s_r.match_value;
        end
        if (apply[SY_PIT]) begin
            s_nxt.pctrl_act = s_r.pctrl;
        end

        // Prescaler
        if (!s_r.ctrla_act[ON_BIT]) begin
            s_nxt.pre_cnt = 15'h0000;
        end else if (tick && run_cnt) begin
            s_nxt.pre_cnt = s_r.pre_cnt + 15'h0001;
        end

        // Main counter
        if (apply[SY_CNT]) begin
            s_nxt.tick_count = s_r.cnt_wr;
        end else if (div_tick) begin
            if (s_r.tick_count == s_r.top_act) begin
                s_nxt.tick_count = ZERO16;
                wrap_evt         = 1'b1;
            end else begin
                s_nxt.tick_count = s_r.tick_count + 16'h0001;
            end
            match_evt = (s_nxt.tick_count == s_r.match_act);
        end

        // Periodic interval on undivided ticks
        if (!pit_on) begin
            s_nxt.pit_cnt = ZERO16;
        end else if (tick && pit_run) begin
            if (s_r.pit_cnt >= pit_last) begin
                s_nxt.pit_cnt = ZERO16;
                pit_evt       = 1'b1;
            end else begin
                s_nxt.pit_cnt = s_r.pit_cnt + 16'h0001;
            end
        end

        // Register writes; a write restarts its crossing
        if (wr) begin
            if (idx == IDX_CTRLA) begin
                s_nxt.ctrla               = wd & CTRLA_MASK;
                s_nxt.pend[SY_CTRLA]      = 1'b1;
                s_nxt.sync_cnt[SY_CTRLA]  = 2'h0;
            end else if (idx == IDX_INTCTRL) begin
                s_nxt.int_en = wd[1:0];
            end else if (idx == IDX_INTFLAGS) begin
                flag_clr = wd[1:0];
            end else if (idx == IDX_TEMP) begin
                s_nxt.temp = wd;
            end else if (idx == IDX_HALT) begin
                s_nxt.halt_bypass = wd[0];
            end else if (idx == IDX_SRCSEL) begin
                s_nxt.source_select = wd[1:0];
            end else if (idx == IDX_CNT_L || idx == IDX_TOP_L || idx == IDX_MATCH_L) begin
                s_nxt.temp = wd;
            end else if (idx == IDX_CNT_H) begin
                s_nxt.cnt_wr           = {wd, s_r.temp};
                s_nxt.pend[SY_CNT]     = 1'b1;
                s_nxt.sync_cnt[SY_CNT] = 2'h0;
            end else if (idx == IDX_TOP_H) begin
                s_nxt.wrap_top         = {wd, s_r.temp};
                s_nxt.pend[SY_TOP]     = 1'b1;
                s_nxt.sync_cnt[SY_TOP] = 2'h0;
            end else if (idx == IDX_MATCH_H) begin
                s_nxt.match_value        = {wd, s_r.temp};
                s_nxt.pend[SY_MATCH]     = 1'b1;
                s_nxt.sync_cnt[SY_MATCH] = 2'h0;
            end else if (idx == IDX_PCTRL) begin
                s_nxt.pctrl            = wd & PCTRL_MASK;
                s_nxt.pend[SY_PIT]     = 1'b1;
                s_nxt.sync_cnt[SY_PIT] = 2'h0;
            end else if (idx == IDX_PIRQEN) begin
                s_nxt.pit_ie = wd[0];
            end else if (idx == IDX_PDBG) begin
                s_nxt.pit_bypass = wd[0];
            end
        end

        // Sticky flags: a set in the clearing cycle wins
        s_nxt.int_flag = (s_r.int_flag & ~flag_clr) | {match_evt, wrap_evt};
        s_nxt.periodic_irq = (s_r.periodic_irq
                              & ~(wr && idx == IDX_PFLAGS && wd[0])) | pit_evt;
        s_nxt.rtc_irq = |(s_nxt.int_flag & s_r.int_en);
        s_nxt.pit_irq = s_nxt.periodic_irq & s_r.pit_ie;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.wrap_top <= TOP_RST;
            s_r.top_act  <= TOP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign prdata           = s_r.prdata;
    assign pready           = s_r.pready;
    assign pslverr          = s_r.pslverr;
    assign rtc_irq_req      = s_r.rtc_irq;
    assign periodic_irq_req = s_r.pit_irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence cnt_write_s;
        wr && idx == IDX_CNT_H;
    endsequence

    sequence pctrl_write_s;
        wr && idx == IDX_PCTRL;
    endsequence

    halt_freeze_a: assert property (dbg_halt && !s_r.halt_bypass
                                    && !s_r.pend[SY_CNT] |=> $stable(s_r.tick_count))
        else $error("counter moved during debug halt");

    cnt_pending_a: assert property (cnt_write_s |=> s_r.pend[SY_CNT]
                                    ##0 (s_r.cnt_wr[15:8] == $past(wd)))
        else $error("counter write did not raise pending");

    cnt_latency_a: assert property ($fell(s_r.pend[SY_CNT]) |->
                                    $past(tick) && $past(s_r.sync_cnt[SY_CNT]) == 2'h1)
        else $error("counter write landed before two ticks");

    top_apply_a: assert property ($fell(s_r.pend[SY_TOP]) |->
                                  s_r.top_act == $past(s_r.wrap_top))
        else $error("wrap top not applied after sync");

    pit_busy_a: assert property (pctrl_write_s |=> s_r.pend[SY_PIT]
                                 ##1 s_r.pend[SY_PIT] || $past(tick))
        else $error("periodic status not busy after write");

    pit_code_a: assert property (pit_evt |-> period != PIT_OFF
                                 && period != PIT_RSVD && s_r.pit_cnt == pit_last)
        else $error("periodic event at wrong count");

    pit_flag_a: assert property (pit_evt |=> s_r.periodic_irq)
        else $error("periodic flag not set");

    pit_gate_a: assert property (s_r.pit_irq |-> $past(s_r.pit_ie))
        else $error("periodic request while disabled");

    wrap_zero_a: assert property (wrap_evt |=> s_r.int_flag[0]
                                  && s_r.tick_count == ZERO16)
        else $error("wrap did not clear counter");

    match_flag_a: assert property (match_evt |=> s_r.int_flag[1])
        else $error("match flag not set");

    cnt_off_a: assert property (!s_r.ctrla_act[ON_BIT]
                                && !apply[SY_CNT] |=> $stable(s_r.tick_count))
        else $error("counter moved while off");

endmodule : rcpt_core

// file: tb_top.sv
/* Self-checking bench for rcpt_core over APB.
   Assumes one APB wait state and timebase pins far slower than pclk. */
`timescale 1ns/1ps
module tb_top;
    import rcpt_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, fclk = 1'b0, sclk = 1'b0, xclk = 1'b0, dbg_halt = 1'b0;
    logic [7:0]  paddr = 8'h00, d, e;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, se, rtc_irq_req, periodic_irq_req;
    int          errors = 0, num_checks = 0, cyc = 0;
    logic [5:0]  ri [15] = '{IDX_CTRLA, IDX_STATUS, IDX_HALT, IDX_SRCSEL, IDX_CNT_L,
        IDX_CNT_H, IDX_TOP_L, IDX_TOP_H, IDX_MATCH_L, IDX_MATCH_H, IDX_PCTRL, IDX_PSTAT,
        IDX_PIRQEN, IDX_PFLAGS, IDX_PDBG};
    logic [7:0]  rv [15] = '{0, 0, 0, 0, 0, 0, 8'hFF, 8'hFF, 0, 0, 0, 0, 0, 0, 0};
    logic [1:0]  sv [3] = '{SRC_FAST, SRC_SLOW, SRC_EXT};
    int          lo [3] = '{55, 245, 26};
    int          hi [3] = '{76, 268, 40};
    // Clocks, timebase pins not aligned to pclk
    always #50 pclk = ~pclk;
    always #813 fclk = ~fclk;
    always #3207 sclk = ~sclk;
    always #409 xclk = ~xclk;
    always @(posedge pclk) cyc <= cyc + 1;
    rcpt_core rcpt_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_internal_source_clk(fclk),
        .slow_internal_source_clk(sclk), .external_pin_source_clk(xclk),
        .dbg_halt(dbg_halt), .rtc_irq_req(rtc_irq_req), .periodic_irq_req(periodic_irq_req));
    // Verdict and end of run
    task test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    // A wait that ran out counts as a mismatch
    task tmo(input string nm);
        errors++;
        $display("mismatch %s expected done seen timeout", nm);
        test_done();
    endtask : tmo
    // One APB transfer, held until pready
    task xfer(input logic w, input logic [5:0] i, input logic [7:0] v);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) tmo("pready");
        d = prdata[7:0];
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task wr(input logic [5:0] i, input logic [7:0] v);
        xfer(1'b1, i, v);
    endtask : wr
    task waitb(input logic [5:0] i, input logic [7:0] m, input logic [7:0] x);
        for (int k = 0; k < 300; k++) begin
            xfer(1'b0, i, 8'h00);
            if ((d & m) === x) return;
        end
        tmo("busy_wait");
    endtask : waitb
    task waiti;
        int k;
        for (k = 0; k < 3000 && periodic_irq_req !== 1'b1; k++) @(posedge pclk);
        if (k >= 3000) tmo("pit_wait");
    endtask : waiti
    // Spacing of two periodic events, flag cleared in between
    task gap(input int l, input int h);
        int t0;
        waiti();
        wr(IDX_PFLAGS, 8'h01);
        repeat (2) @(posedge pclk);
        waiti();
        t0 = cyc;
        wr(IDX_PFLAGS, 8'h01);
        repeat (2) @(posedge pclk);
        waiti();
        chk("pit_gap", 16'h1, 16'(cyc - t0 >= l && cyc - t0 <= h));
    endtask : gap
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ri[j]) begin
            xfer(1'b0, ri[j], 8'h00);
            chk("reset_value", rv[j], d);
        end
        xfer(1'b0, 6'h06, 8'h00);
        chk("unmapped", 16'h0100, {se, d});
        wr(IDX_MATCH_L, 8'h05);
        wr(IDX_MATCH_H, 8'h00);
        wr(IDX_TOP_L, 8'h07);
        wr(IDX_TOP_H, 8'h00);
        xfer(1'b0, IDX_STATUS, 8'h00);
        chk("top_busy", 16'h1, d[2]);
        waitb(IDX_STATUS, 8'h0F, 8'h00);
        wr(IDX_CNT_L, 8'h03);
        wr(IDX_CNT_H, 8'h00);
        xfer(1'b0, IDX_STATUS, 8'h00);
        chk("cnt_busy", 16'h1, d[1]);
        waitb(IDX_STATUS, 8'h0F, 8'h00);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        chk("cnt_low", 16'h03, d);
        xfer(1'b0, IDX_MATCH_L, 8'h00);
        chk("match_low", 16'h05, d);
        // Run the counter to match and wrap
        wr(IDX_INTCTRL, 8'h03);
        wr(IDX_CTRLA, 8'h01);
        waitb(IDX_INTFLAGS, 8'h03, 8'h03);
        chk("rtc_irq", 16'h1, rtc_irq_req);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        chk("cnt_below_top", 16'h1, 16'(d <= 8'h07));
        // Debug halt freezes the counter
        dbg_halt <= 1'b1;
        repeat (40) @(posedge pclk);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        e = d;
        repeat (100) @(posedge pclk);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        chk("halt_count", e, d);
        dbg_halt <= 1'b0;
        wr(IDX_CTRLA, 8'h00);
        waitb(IDX_STATUS, 8'h01, 8'h00);
        wr(IDX_INTFLAGS, 8'h03);
        xfer(1'b0, IDX_INTFLAGS, 8'h00);
        chk("flags_clear", 16'h0, d);
        // Prescaler /4 gives a quarter of the ticks; off then holds the count
        wr(IDX_TOP_L, 8'hFF);
        wr(IDX_TOP_H, 8'h00);
        waitb(IDX_STATUS, 8'h04, 8'h00);
        wr(IDX_CNT_L, 8'h00);
        wr(IDX_CNT_H, 8'h00);
        waitb(IDX_STATUS, 8'h02, 8'h00);
        wr(IDX_CTRLA, 8'h11);
        waitb(IDX_STATUS, 8'h01, 8'h00);
        repeat (1040) @(posedge pclk);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        chk("prescale", 16'h1, 16'(d >= 8'h0F && d <= 8'h11));
        wr(IDX_CTRLA, 8'h00);
        waitb(IDX_STATUS, 8'h01, 8'h00);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        e = d;
        repeat (200) @(posedge pclk);
        xfer(1'b0, IDX_CNT_L, 8'h00);
        chk("off_count", e, d);
        // Periodic timer on each source
        wr(IDX_PIRQEN, 8'h01);
        wr(IDX_PCTRL, 8'h09);
        xfer(1'b0, IDX_PSTAT, 8'h00);
        chk("pit_busy", 16'h1, d);
        foreach (sv[j]) begin
            wr(IDX_SRCSEL, {6'h00, sv[j]});
            gap(lo[j], hi[j]);
        end
        wr(IDX_PDBG, 8'h01);
        dbg_halt <= 1'b1;
        gap(lo[2], hi[2]);
        // Bypass off: the periodic timer halts with the processor
        wr(IDX_PDBG, 8'h00);
        wr(IDX_PFLAGS, 8'h01);
        repeat (300) @(posedge pclk);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("pit_halted", 16'h0, d);
        dbg_halt <= 1'b0;
        // Reserved source gives no ticks
        wr(IDX_SRCSEL, {6'h00, SRC_RSVD});
        wr(IDX_PFLAGS, 8'h01);
        repeat (300) @(posedge pclk);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("rsvd_source", 16'h0, d);
        wr(IDX_SRCSEL, {6'h00, SRC_EXT});
        wr(IDX_PIRQEN, 8'h00);
        wr(IDX_PFLAGS, 8'h01);
        waitb(IDX_PFLAGS, 8'h01, 8'h01);
        chk("pit_gate", 16'h0, periodic_irq_req);
        // Reserved interval code never fires
        wr(IDX_PCTRL, 8'h79);
        waitb(IDX_PSTAT, 8'h01, 8'h00);
        wr(IDX_PFLAGS, 8'h01);
        repeat (300) @(posedge pclk);
        xfer(1'b0, IDX_PFLAGS, 8'h00);
        chk("pit_reserved", 16'h0, d);
        test_done();
    end
endmodule : tb_top
